// ---- design/lvsr_regs.sv ----
// LED voltage status and customer trim registers behind the serial port
// ----------------------------------------------------------------
// How it works
// - Frame bits 23..16 of the status word give the channel 1 off-time LED voltage code, cleared by its read.
// - Frame bits 15..8 give the channel 2 off-time LED voltage code, zero after reset.
// - A channel switched by pin or command refreshes its reading on every cycle it is off.
// - A PWM-dimmed channel refreshes only on the pulse just before its off phase ends.
// - Every 24-bit frame ends in an odd parity bit, checked on entry and made on exit.
// - The watchdog band reports 00 below 24, 01 to 50, 10 to 74 and 11 up to 100 percent.
// - The trim opcode selects read, margin read, blank check, burn or end, 000 after reset.
// - Burn data are taken only with opcode 100 and while trimming is not finished.
// - A blank check loads the eight fuse cells into trim bits 20..13 for read-back.
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "lvsr_params.svh"

module lvsr_regs #(
	parameter int WD_PERIOD = 1000
) (
	// Clock and reset
	input  logic            i_clk,
	input  logic            i_nrst,
	input  logic            i_ce,
	// Serial port pins
	input  logic            i_sck,
	input  logic            i_csn,
	input  logic            i_sdi,
	output logic            o_sdo,
	output logic            o_sdo_oe_n,
	// Converter side, per channel
	input  logic [1:0][7:0] i_adc,
	input  logic [1:0]      i_buck_off,
	input  logic [1:0]      i_pwm_mode,
	input  logic [1:0]      i_pwm_off_end,
	// Watchdog
	input  logic [15:0]     i_wd_elapsed,
	output logic [1:0]      o_watchdog_elapsed_band,
	// Fuse array
	input  logic [7:0]      i_fuse_cells,
	output logic [2:0]      o_trim_opcode,
	output logic            o_burn_start,
	output logic [7:0]      o_burn_bits,
	output logic            o_trimming_finished,
	// Power-up defaults
	output logic [1:0]      o_default_high_current_range,
	output logic [1:0]      o_default_peak_dac_ch1,
	output logic [1:0]      o_default_volt_offtime_ch1
);

	// Period must fit the 16-bit elapsed count
	if (WD_PERIOD < 1 || WD_PERIOD > 65535) begin : g_bad_period
		$error("WD_PERIOD out of range");
	end

	lvsr_pkg::lvsr_top_state_t st_r;
	lvsr_pkg::lvsr_top_state_t st_nxt;
	logic [1:0][7:0]           ledv;
	logic                      sck_rise;
	logic                      sck_fall;
	logic                      csn_fall;
	logic                      csn_rise;
	logic                      frame_ok;
	logic                      is_write;
	logic                      is_read;
	logic [5:0]                addr;
	logic [31:0]               wd_scaled;
	logic [31:0]               wd_full;

	// ----------------------------------------------------------------
	// Parity helpers
	// ----------------------------------------------------------------
	function automatic logic lvsr_odd_ok(input logic [23:0] w);
		lvsr_odd_ok = ^w;
	endfunction : lvsr_odd_ok

	function automatic logic [23:0] lvsr_seal(input logic [22:0] w);
		lvsr_seal = {w, ~^w};
	endfunction : lvsr_seal

	// ----------------------------------------------------------------
	// Channel readings
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			lvsr_capture u_cap (
				.i_clk        (i_clk),
				.i_nrst       (i_nrst),
				.i_ce         (i_ce),
				.i_adc        (i_adc[g]),
				.i_buck_off   (i_buck_off[g]),
				.i_pwm_mode   (i_pwm_mode[g]),
				.i_pwm_off_end(i_pwm_off_end[g]),
				.i_clear      (st_r.clr_sr),
				.o_value      (ledv[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Frame decode
	// ----------------------------------------------------------------
	// Edges only from the second and third stages
	assign sck_rise = st_r.sck_p[1] && !st_r.sck_p[2];
	assign sck_fall = !st_r.sck_p[1] && st_r.sck_p[2];
	assign csn_fall = !st_r.csn_p[1] && st_r.csn_p[2];
	assign csn_rise = st_r.csn_p[1] && !st_r.csn_p[2];
	assign frame_ok = csn_rise && st_r.cnt == `LVSR_FRAME_BITS
		&& lvsr_odd_ok(st_r.rx);
	assign is_write = st_r.rx[`LVSR_FRM_OP_HI:`LVSR_FRM_OP_LO] == `LVSR_OP_WRITE;
	assign is_read  = st_r.rx[`LVSR_FRM_OP_HI:`LVSR_FRM_OP_LO] == `LVSR_OP_READ;
	assign addr     = st_r.rx[`LVSR_FRM_ADDR_HI:`LVSR_FRM_ADDR_LO];
	assign wd_scaled = {16'h0000, i_wd_elapsed} * `LVSR_WD_PCT_FULL;
	assign wd_full   = 32'(WD_PERIOD);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.sck_p = {st_r.sck_p[1:0], i_sck};
		st_nxt.csn_p = {st_r.csn_p[1:0], i_csn};
		st_nxt.sdi_p = {st_r.sdi_p[0], i_sdi};
		st_nxt.burn_start = 1'b0;
		st_nxt.clr_sr = 1'b0;

		// Shift engine: sample on rise, drive on fall
		if (csn_fall) begin
			st_nxt.cnt = 5'h00;
			st_nxt.tx = {st_r.next_tx[22:0], 1'b0};
			st_nxt.sdo = st_r.next_tx[23];
			st_nxt.sdo_oe_n = 1'b0;
		end else if (!st_r.csn_p[1]) begin
			if (sck_rise) begin
				st_nxt.rx = {st_r.rx[22:0], st_r.sdi_p[1]};
				if (st_r.cnt != 5'h1F) begin
					st_nxt.cnt = st_r.cnt + 5'h01;
				end
			end
			if (sck_fall) begin
				st_nxt.sdo = st_r.tx[23];
				st_nxt.tx = {st_r.tx[22:0], 1'b0};
			end
		end
		if (csn_rise) begin
			st_nxt.sdo_oe_n = 1'b1;
		end

		// Command execution, bad parity or length drops the frame
		if (frame_ok && is_read) begin
			case (addr)
				`LVSR_ADDR_LED_VOLTAGE_STATUS: begin
					st_nxt.next_tx = lvsr_seal({ledv[0], ledv[1], 7'h00});
					st_nxt.clr_sr = 1'b1;
				end
				`LVSR_ADDR_CUSTOMER_TRIM_CONTROL: begin
					st_nxt.next_tx = lvsr_seal({st_r.opcode, st_r.fuse,
						st_r.trimming_finished, 11'h000});
				end
				default: begin
					st_nxt.next_tx = lvsr_seal(23'h000000);
				end
			endcase
		end
		if (frame_ok && is_write && addr == `LVSR_ADDR_CUSTOMER_TRIM_CONTROL
			&& !st_r.trimming_finished) begin
			st_nxt.opcode = lvsr_pkg::lvsr_trim_op_t'(
				st_r.rx[`LVSR_CT_OPC_HI:`LVSR_CT_OPC_LO]);
			case (st_r.rx[`LVSR_CT_OPC_HI:`LVSR_CT_OPC_LO])
				lvsr_pkg::LVSR_TRIM_BURN: begin
					st_nxt.fuse = st_r.rx[`LVSR_CT_FUSE_HI:`LVSR_CT_FUSE_LO];
					st_nxt.burn_bits = st_r.rx[`LVSR_CT_FUSE_HI:`LVSR_CT_FUSE_LO];
					st_nxt.burn_start = 1'b1;
				end
				lvsr_pkg::LVSR_TRIM_READ,
				lvsr_pkg::LVSR_TRIM_MARGIN,
				lvsr_pkg::LVSR_TRIM_BLANK: begin
					// Fuse array answers one cycle after the mode shows
					st_nxt.load_pend = 1'b1;
				end
				lvsr_pkg::LVSR_TRIM_END: begin
					st_nxt.trimming_finished = 1'b1;
				end
				default: begin
					st_nxt.load_pend = 1'b0;
				end
			endcase
		end else if (st_r.load_pend) begin
			st_nxt.fuse = i_fuse_cells;
			st_nxt.load_pend = 1'b0;
		end

		// Watchdog band from elapsed fraction
		if (wd_scaled < `LVSR_WD_PCT_24 * wd_full) begin
			st_nxt.wd_band = 2'h0;
		end else if (wd_scaled < `LVSR_WD_PCT_50 * wd_full) begin
			st_nxt.wd_band = 2'h1;
		end else if (wd_scaled < `LVSR_WD_PCT_74 * wd_full) begin
			st_nxt.wd_band = 2'h2;
		end else begin
			st_nxt.wd_band = 2'h3;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r <= '0;
			st_r.csn_p <= 3'h7;
			st_r.sdo_oe_n <= 1'b1;
			st_r.next_tx <= 24'h000001;
			st_r.opcode <= lvsr_pkg::LVSR_TRIM_IDLE;
			st_r.fuse <= `LVSR_RST_FUSE;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_sdo = st_r.sdo;
	assign o_sdo_oe_n = st_r.sdo_oe_n;
	assign o_watchdog_elapsed_band = st_r.wd_band;
	assign o_trim_opcode = st_r.opcode;
	assign o_burn_start = st_r.burn_start;
	assign o_burn_bits = st_r.burn_bits;
	assign o_trimming_finished = st_r.trimming_finished;
	assign o_default_high_current_range = st_r.fuse[7:6];
	assign o_default_peak_dac_ch1 = st_r.fuse[5:4];
	assign o_default_volt_offtime_ch1 = st_r.fuse[3:2];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	eot_lock_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st_r.trimming_finished |=> st_r.trimming_finished && $stable(st_r.opcode) && !st_r.burn_start)
		else $error("trim changed after end of trimming");

	burn_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		st_r.burn_start |-> st_r.opcode == lvsr_pkg::LVSR_TRIM_BURN
		&& st_r.fuse == st_r.burn_bits && !$past(st_r.trimming_finished))
		else $error("burn without burn opcode");

	blank_load_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && st_r.load_pend && st_r.opcode == lvsr_pkg::LVSR_TRIM_BLANK
		|=> st_r.fuse == $past(i_fuse_cells))
		else $error("blank check not loaded");

	band_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && wd_scaled < `LVSR_WD_PCT_24 * wd_full |=> o_watchdog_elapsed_band == 2'h0)
		else $error("watchdog band wrong below 24 percent");

	band_top_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && wd_scaled >= `LVSR_WD_PCT_74 * wd_full |=> o_watchdog_elapsed_band == 2'h3)
		else $error("watchdog band wrong above 74 percent");

	read_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && frame_ok && is_read && addr == `LVSR_ADDR_LED_VOLTAGE_STATUS
		|=> st_r.clr_sr && st_r.next_tx[23:16] == $past(ledv[0]))
		else $error("status read not cleared");

	tx_parity_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		csn_fall |-> ^st_r.next_tx)
		else $error("outgoing frame not odd parity");

	bad_parity_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && csn_rise && !lvsr_odd_ok(st_r.rx)
		|=> $stable(st_r.opcode) && $stable(st_r.next_tx))
		else $error("bad parity frame executed");

	defaults_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && st_r.load_pend && !frame_ok
		|=> {o_default_high_current_range, o_default_peak_dac_ch1,
		o_default_volt_offtime_ch1} == $past(i_fuse_cells[7:2]))
		else $error("default outputs not from loaded trim bits");

	burn_c: cover property (@(posedge i_clk) disable iff (!i_nrst) st_r.burn_start);
	eot_c: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(st_r.trimming_finished));
	sr_read_c: cover property (@(posedge i_clk) disable iff (!i_nrst) st_r.clr_sr);

endmodule : lvsr_regs

// ---- shared/lvsr_params.svh ----
// Offsets, field positions, reset values and watchdog band limits of the LED voltage and trim registers
`ifndef LVSR_PARAMS_SVH
`define LVSR_PARAMS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define LVSR_FRAME_BITS     5'h18
`define LVSR_OP_WRITE       2'h0
`define LVSR_OP_READ        2'h1
`define LVSR_FRM_OP_HI      23
`define LVSR_FRM_OP_LO      22
`define LVSR_FRM_ADDR_HI    21
`define LVSR_FRM_ADDR_LO    16

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LVSR_ADDR_LED_VOLTAGE_STATUS    6'h07
`define LVSR_ADDR_CUSTOMER_TRIM_CONTROL 6'h3E

// ----------------------------------------------------------------
// Field positions of the trim register (frame bits = register - 8)
// ----------------------------------------------------------------
`define LVSR_CT_OPC_HI      15
`define LVSR_CT_OPC_LO      13
`define LVSR_CT_FUSE_HI     12
`define LVSR_CT_FUSE_LO     5
`define LVSR_CT_EOT         4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LVSR_RST_OPCODE     3'h0
`define LVSR_RST_FUSE       8'h01
`define LVSR_RST_LEDV       8'h00

// ----------------------------------------------------------------
// Watchdog band limits, percent of the period
// ----------------------------------------------------------------
`define LVSR_WD_PCT_24      32'h00000018
`define LVSR_WD_PCT_50      32'h00000032
`define LVSR_WD_PCT_74      32'h0000004A
`define LVSR_WD_PCT_FULL    32'h00000064

`endif

// ---- shared/lvsr_pkg.sv ----
// Types of the LED voltage and trim register block
package lvsr_pkg;

	typedef enum logic [2:0] {
		LVSR_TRIM_IDLE   = 3'b000,
		LVSR_TRIM_READ   = 3'b001,
		LVSR_TRIM_MARGIN = 3'b010,
		LVSR_TRIM_BLANK  = 3'b011,
		LVSR_TRIM_BURN   = 3'b100,
		LVSR_TRIM_END    = 3'b111
	} lvsr_trim_op_t;

	typedef struct packed {
		logic [7:0] value;
	} lvsr_cap_state_t;

	typedef struct packed {
		logic [2:0]    sck_p;
		logic [2:0]    csn_p;
		logic [1:0]    sdi_p;
		logic [23:0]   rx;
		logic [4:0]    cnt;
		logic [23:0]   tx;
		logic [23:0]   next_tx;
		logic          sdo;
		logic          sdo_oe_n;
		lvsr_trim_op_t opcode;
		logic [7:0]    fuse;
		logic          trimming_finished;
		logic          load_pend;
		logic          burn_start;
		logic [7:0]    burn_bits;
		logic          clr_sr;
		logic [1:0]    wd_band;
	} lvsr_top_state_t;

endpackage : lvsr_pkg

// ---- design/lvsr_capture.sv ----
// Off-time LED voltage holding register of one buck channel
`timescale 1ns/1ns
`include "lvsr_params.svh"

module lvsr_capture (
	// Clock and reset
	input  logic       i_clk,
	input  logic       i_nrst,
	input  logic       i_ce,
	// Converter side
	input  logic [7:0] i_adc,
	input  logic       i_buck_off,
	input  logic       i_pwm_mode,
	input  logic       i_pwm_off_end,
	// Register side
	input  logic       i_clear,
	output logic [7:0] o_value
);

	lvsr_pkg::lvsr_cap_state_t st_r;
	lvsr_pkg::lvsr_cap_state_t st_nxt;
	logic                      upd;

	// ----------------------------------------------------------------
	// Refresh and read-and-clear
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		upd = i_pwm_mode ? i_pwm_off_end : i_buck_off;
		if (upd) begin
			st_nxt.value = i_adc;
		end else if (i_clear) begin
			// Fresh sample wins over a read in the same cycle
			st_nxt.value = `LVSR_RST_LEDV;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r.value <= `LVSR_RST_LEDV;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_value = st_r.value;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	cont_refresh_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && !i_pwm_mode && i_buck_off |=> o_value == $past(i_adc))
		else $error("reading not refreshed while off");

	pwm_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && i_pwm_mode && !i_pwm_off_end && !i_clear |=> $stable(o_value))
		else $error("pwm reading changed outside off-end");

	clear_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && i_clear && !upd |=> o_value == 8'h00)
		else $error("reading not cleared");

	pwm_cap_c: cover property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && i_pwm_mode && i_pwm_off_end);

endmodule : lvsr_capture

// ---- sim/lvsr_host.sv ----
// Serial master model of the host that frames register transfers
`timescale 1ns/1ns

module lvsr_host (
	// Clock
	input  logic i_clk,
	// Serial port pins
	output logic o_sck,
	output logic o_csn,
	output logic o_sdi,
	input  logic i_sdo,
	input  logic i_sdo_oe_n
);
	// ----
	// Transfers
	// ----
	// Half period well above the 3-clock floor of the synchronisers
	localparam int HALF = 10;

	initial begin
		o_sck = 1'b0;
		o_csn = 1'b1;
		o_sdi = 1'b0;
	end

	task automatic xfer(input logic [22:0] body, input logic bad,
		output logic [23:0] ans, output logic oe_bad);
		logic [23:0] frm;
		frm = {body, ~^body ^ bad};
		oe_bad = 1'b0;
		@(posedge i_clk);
		o_csn <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			o_sdi <= frm[i];
			repeat (HALF) @(posedge i_clk);
			o_sck <= 1'b1;
			ans[i] = i_sdo;
			oe_bad = oe_bad | i_sdo_oe_n;
			repeat (HALF) @(posedge i_clk);
			o_sck <= 1'b0;
		end
		repeat (HALF) @(posedge i_clk);
		o_csn <= 1'b1;
		// Released line shows the inverse, not a stale copy
		o_sdi <= ~frm[0];
		repeat (12) @(posedge i_clk);
	endtask : xfer

	// Burn time 2.85 us plus 401 us per selected bit, in 40 ns cycles
	task automatic burn_wait(input int nbits);
		repeat ((2850 + 401000 * nbits) / 40) @(posedge i_clk);
	endtask : burn_wait

endmodule : lvsr_host

// ---- sim/tb.sv ----
// Self-checking bench of the LED voltage status and trim registers
`timescale 1ns/1ns

module tb;
	// ----
	// Signals and reference state
	// ----
	localparam int WDP = 100;
	logic            clk = 1'b0;
	logic            nrst = 1'b0;
	logic            sck;
	logic            csn;
	logic            sdi;
	logic            sdo;
	logic            oe_n;
	logic [1:0][7:0] adc = '0;
	logic [1:0]      boff = 2'h0;
	logic [1:0]      pwm = 2'h0;
	logic [1:0]      pend = 2'h0;
	logic [15:0]     wd = 16'h0000;
	logic [7:0]      cells = 8'h00;
	logic [1:0]      band;
	logic [2:0]      opc;
	logic            bst;
	logic [7:0]      bbits;
	logic            fin;
	logic [5:0]      dflt;
	logic [23:0]     exp_w;
	logic            ev = 1'b0;
	int              fails = 0, checks = 0, burns = 0;
	int              m_op = 0, m_fuse = 1, m_eot = 0;
	int              m_ch1 = 0, m_ch2 = 0, m_burns = 0;

	always #20 clk = ~clk;

	lvsr_regs #(.WD_PERIOD(WDP)) u_lvsr_regs (
		.i_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
		.i_sck(sck), .i_csn(csn), .i_sdi(sdi),
		.o_sdo(sdo), .o_sdo_oe_n(oe_n),
		.i_adc(adc), .i_buck_off(boff), .i_pwm_mode(pwm),
		.i_pwm_off_end(pend), .i_wd_elapsed(wd),
		.o_watchdog_elapsed_band(band), .i_fuse_cells(cells),
		.o_trim_opcode(opc), .o_burn_start(bst), .o_burn_bits(bbits),
		.o_trimming_finished(fin),
		.o_default_high_current_range(dflt[5:4]),
		.o_default_peak_dac_ch1(dflt[3:2]),
		.o_default_volt_offtime_ch1(dflt[1:0])
	);

	lvsr_host u_lvsr_host (
		.i_clk(clk), .o_sck(sck), .o_csn(csn), .o_sdi(sdi),
		.i_sdo(sdo), .i_sdo_oe_n(oe_n)
	);

	always @(posedge clk) if (bst === 1'b1) burns <= burns + 1;

	// ----
	// Checks
	// ----
	task automatic chk(input string n, input logic [23:0] e,
		input logic [23:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic done(input string n);
		$display("test %s ended, %0d mismatches", n, fails);
	endtask : done

	task automatic report_and_stop();
		$display("%0d checks, %0d mismatches", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	function automatic logic [23:0] w(input logic [22:0] b);
		return {b, ~^b};
	endfunction : w

	function automatic int bnd(input int x);
		int p;
		p = x * 100 / WDP;
		return (p < 24) ? 0 : (p < 50) ? 1 : (p < 74) ? 2 : 3;
	endfunction : bnd

	// Answers trail by one frame, so the model keeps the pending word
	task automatic frm(input logic [1:0] op, input logic [5:0] a,
		input logic [14:0] d, input logic bad);
		logic [23:0] ans;
		logic        oeb;
		u_lvsr_host.xfer({op, a, d}, bad, ans, oeb);
		if (ev) begin
			chk("answer", exp_w, ans);
		end
		chk("sdo enable", 24'h0, 24'(oeb));
		ev = !bad && op == 2'h1;
		if (ev && a == 6'h07) begin
			exp_w = w({m_ch1[7:0], m_ch2[7:0], 7'h0});
			m_ch1 = 0;
			m_ch2 = 0;
		end else if (ev) begin
			exp_w = (a == 6'h3E) ?
				w({m_op[2:0], m_fuse[7:0], m_eot[0], 11'h0}) : 24'h000001;
		end else if (!bad && a == 6'h3E && m_eot == 0) begin
			m_op = d[14:12];
			m_eot = (m_op == 7) ? 1 : 0;
			m_burns += (m_op == 4) ? 1 : 0;
			m_fuse = (m_op == 4) ? d[11:4] :
				(m_op inside {1, 2, 3}) ? cells : m_fuse;
		end
		chk("opcode", 24'(m_op), 24'(opc));
		chk("finished", 24'(m_eot), 24'(fin));
		chk("burns", 24'(m_burns), 24'(burns));
		chk("defaults", 24'(m_fuse[7:2]), 24'(dflt));
	endtask : frm

	// ----
	// Tests
	// ----
	initial begin
		logic [7:0] a1;
		logic [7:0] a2;
		int         wq[$];
		wq = '{0, 23, 24, 49, 50, 73, 74, 99};
		void'($urandom(98));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		chk("sdo enable idle", 24'h1, 24'(oe_n));
		frm(2'h1, 6'h3E, 15'h0, 1'b0);
		frm(2'h1, 6'h00, 15'h0, 1'b0);
		done("reset");
		// Switched off: reading follows the last code
		a1 = 8'($urandom);
		a2 = 8'($urandom);
		boff <= 2'h3;
		adc <= {~a2, ~a1};
		repeat (3) @(posedge clk);
		adc <= {a2, a1};
		repeat (3) @(posedge clk);
		boff <= 2'h0;
		adc <= {a1, a2};
		m_ch1 = a1;
		m_ch2 = a2;
		repeat (3) @(posedge clk);
		frm(2'h1, 6'h07, 15'h0, 1'b0);
		frm(2'h1, 6'h07, 15'h0, 1'b0);
		// PWM dimmed: only the end-of-off pulse loads
		pwm <= 2'h3;
		boff <= 2'h3;
		adc <= {8'h5A, a2};
		repeat (3) @(posedge clk);
		pend <= 2'h1;
		@(posedge clk);
		pend <= 2'h0;
		adc <= {8'hA5, a1};
		m_ch1 = a2;
		repeat (3) @(posedge clk);
		frm(2'h1, 6'h07, 15'h0, 1'b0);
		frm(2'h1, 6'h00, 15'h0, 1'b0);
		pwm <= 2'h0;
		boff <= 2'h0;
		done("status");
		foreach (wq[i]) begin
			wd <= 16'(wq[i]);
			repeat (3) @(posedge clk);
			chk("band", 24'(bnd(wq[i])), 24'(band));
		end
		done("watchdog");
		for (int k = 1; k < 4; k++) begin
			cells <= 8'($urandom);
			@(posedge clk);
			frm(2'h0, 6'h3E, {k[2:0], 12'h000}, 1'b0);
			frm(2'h1, 6'h3E, 15'h0, 1'b0);
		end
		frm(2'h0, 6'h3E, {3'h4, 8'hC0, 4'h0}, 1'b1);
		frm(2'h0, 6'h07, 15'h7FFF, 1'b0);
		frm(2'h0, 6'h3E, {3'h4, 8'h81, 4'h0}, 1'b0);
		chk("burn bits", 24'h000081, 24'(bbits));
		u_lvsr_host.burn_wait(2);
		frm(2'h0, 6'h3E, {3'h7, 12'h000}, 1'b0);
		frm(2'h0, 6'h3E, {3'h4, 8'hFF, 4'h0}, 1'b0);
		frm(2'h1, 6'h3E, 15'h0, 1'b0);
		frm(2'h1, 6'h00, 15'h0, 1'b0);
		done("trim");
		report_and_stop();
	end

	// Hang guard, about twice the expected run
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		report_and_stop();
	end

endmodule : tb
